// File: rtl/page_xlate.sv
// What this block does
// - 64 entries, all compared in parallel
// - frame number replaces 20-bit page number
// - lookup only for user and mapped kernel
// - entry layout page,pid,frame,N,D,V,G
// - low stage: frame 31:12, N D V G
// - high stage pid qualifies each lookup
// - high stage reserved bits read zero
// - non-cacheable hit bypasses caches
// - store to write-protected page: modification exception
// - invalid hit raises load or store miss
// - global entry ignores process identifier
// - match on page and (global or pid)
// - hit returns frame, attributes; else miss
// - select register entry number bits 13:8
// - select top bit marks probe failure
// - select number steers indexed read/write
// - reserved select and low bits read zero
// - staging registers are the only data path
// - probe loads matching number or failure bit
// - read loads stages; writes store stages
// - random counter 63 down to 8, reset 63
// - multiple lookup matches set sticky shutdown bit
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "xlate_cfg.svh"
module page_xlate (
    input wire logic clk,
    input wire logic rst,
    input wire xlate_pkg::reg_addr_t reg_addr,
    input wire xlate_pkg::word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output xlate_pkg::word_t reg_rdata,
    input wire logic xl_req,
    input wire xlate_pkg::word_t xl_vaddr,
    input wire logic xl_store,
    input wire logic xl_user_mode,
    output logic xl_done,
    output xlate_pkg::word_t xl_paddr,
    output logic xl_uncached,
    output logic xl_mapped,
    output logic load_miss_exception,
    output logic store_miss_exception,
    output logic user_segment_miss_exception,
    output logic modification_exception,
    output logic shutdown_status_bit
);
    import xlate_pkg::*;

    entry_t tbl_r [`ENTRIES];
    page_t hi_vpn_r;
    logic [5:0] hi_pid_r;
    page_t lo_pfn_r;
    logic [3:0] lo_attr_r;
    slot_t sel_idx_r;
    logic sel_fail_r;
    slot_t rand_r;
    logic shut_r;
    word_t rdata_r;
    logic done_r, unc_r, map_r, lmiss_r, smiss_r, umiss_r, mod_r;
    word_t paddr_r;

    function automatic logic entry_hit(entry_t e, page_t virtual_page_number,
                                       logic [5:0] process_identifier);
        entry_hit = (e.virtual_page_number == virtual_page_number) && (e.g || e.process_identifier == process_identifier);
    endfunction

    function automatic slot_t first_slot(logic [`ENTRIES-1:0] v);
        first_slot = '0;
        for (int i = `ENTRIES - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_slot = slot_t'(i);
            end
        end
    endfunction

    function automatic logic many(logic [`ENTRIES-1:0] v);
        many = (v & (v - 64'h1)) != 64'h0;
    endfunction

    // Parallel compare for lookups and probes
    wire [`ENTRIES-1:0] xl_hits, pr_hits;
    genvar gi;
    generate
        for (gi = 0; gi < `ENTRIES; gi++) begin : g_cmp
            assign xl_hits[gi] = entry_hit(tbl_r[gi],
                xl_vaddr[31:`PAGE_LSB], hi_pid_r);
            assign pr_hits[gi] = entry_hit(tbl_r[gi], hi_vpn_r, hi_pid_r);
        end
    endgenerate

    wire seg_user = ~xl_vaddr[31];
    wire seg_kmap = xl_vaddr[31] & xl_vaddr[30];
    wire mapped_ref = seg_user | seg_kmap;
    wire xl_any = |xl_hits;
    wire xl_multi = many(xl_hits);
    wire slot_t xl_slot = first_slot(xl_hits);
    wire entry_t xl_ent = tbl_r[xl_slot];
    wire pr_any = |pr_hits;
    wire slot_t pr_slot = first_slot(pr_hits);
    wire lookup = xl_req & mapped_ref & ~shut_r;

    wire cmd_wr = reg_wr && reg_addr == `ADDR_CMD;
    wire do_probe = cmd_wr && reg_wdata == `CMD_PROBE;
    wire do_read = cmd_wr && reg_wdata == `CMD_READ;
    wire do_wi = cmd_wr && reg_wdata == `CMD_WRITE_IDX;
    wire do_wr = cmd_wr && reg_wdata == `CMD_WRITE_RAND;
    wire slot_t wr_slot = do_wr ? rand_r : sel_idx_r;
    wire entry_t sel_ent = tbl_r[sel_idx_r];
    wire entry_t stage_ent = '{virtual_page_number: hi_vpn_r, process_identifier: hi_pid_r,
        zero_hi: 6'h00, physical_frame_number: lo_pfn_r, n: lo_attr_r[3], d: lo_attr_r[2],
        v: lo_attr_r[1], g: lo_attr_r[0], zero_lo: 8'h00};

    // Register read decode, reserved bits zero
    wire word_t hi_word = {hi_vpn_r, hi_pid_r, 6'h00};
    wire word_t lo_word = {lo_pfn_r, lo_attr_r, 8'h00};
    wire word_t sel_word = {sel_fail_r, 17'h00000, sel_idx_r,
        8'h00};
    word_t rd_mux;
    always_comb begin
        unique case (reg_addr)
            `ADDR_HIGH: rd_mux = hi_word;
            `ADDR_LOW: rd_mux = lo_word;
            `ADDR_SELECT: rd_mux = sel_word;
            `ADDR_RANDOM: rd_mux = {18'h00000, rand_r, 8'h00};
            `ADDR_STATUS: rd_mux = {31'h00000000, shut_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Entry store, widened to 64 bits with reserved zeros
    always_ff @(posedge clk) begin
        if (do_wi || do_wr) begin
            tbl_r[wr_slot] <= stage_ent;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hi_vpn_r <= 20'h00000;
            hi_pid_r <= 6'h00;
            lo_pfn_r <= 20'h00000;
            lo_attr_r <= 4'h0;
        end else if (do_read) begin
            hi_vpn_r <= sel_ent.virtual_page_number;
            hi_pid_r <= sel_ent.process_identifier;
            lo_pfn_r <= sel_ent.physical_frame_number;
            lo_attr_r <= {sel_ent.n, sel_ent.d, sel_ent.v, sel_ent.g};
        end else if (reg_wr && reg_addr == `ADDR_HIGH) begin
            hi_vpn_r <= reg_wdata[31:12];
            hi_pid_r <= reg_wdata[`HI_PID_MSB:`HI_PID_LSB];
        end else if (reg_wr && reg_addr == `ADDR_LOW) begin
            lo_pfn_r <= reg_wdata[31:12];
            lo_attr_r <= reg_wdata[`LO_N_BIT:`LO_G_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_idx_r <= 6'h00;
            sel_fail_r <= 1'b0;
        end else if (do_probe) begin
            sel_fail_r <= ~pr_any;
            if (pr_any) begin
                sel_idx_r <= pr_slot;
            end
        end else if (reg_wr && reg_addr == `ADDR_SELECT) begin
            sel_fail_r <= reg_wdata[`SEL_PROBE_BIT];
            sel_idx_r <= reg_wdata[`SEL_IDX_MSB:`SEL_IDX_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (rst || rand_r == `RAND_BOT) begin
            rand_r <= `RAND_TOP;
        end else begin
            rand_r <= rand_r - 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shut_r <= 1'b0;
        end else if (lookup && xl_multi) begin
            shut_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    // Lookup result, one cycle after request
    wire good = lookup & xl_any & ~xl_multi;
    always_ff @(posedge clk) begin
        if (rst) begin
            done_r <= 1'b0;
            paddr_r <= 32'h00000000;
            map_r <= 1'b0;
            unc_r <= 1'b0;
            lmiss_r <= 1'b0;
            smiss_r <= 1'b0;
            umiss_r <= 1'b0;
            mod_r <= 1'b0;
        end else begin
            done_r <= xl_req;
            paddr_r <= good ? {xl_ent.physical_frame_number,
                xl_vaddr[`PAGE_LSB-1:0]} : xl_vaddr;
            map_r <= good;
            unc_r <= good & xl_ent.n;
            lmiss_r <= good & ~xl_ent.v & ~xl_store;
            smiss_r <= good & ~xl_ent.v & xl_store;
            mod_r <= good & xl_ent.v & xl_store & ~xl_ent.d;
            umiss_r <= lookup & ~xl_any;
        end
    end

    assign reg_rdata = rdata_r;
    assign xl_done = done_r;
    assign xl_paddr = paddr_r;
    assign xl_uncached = unc_r;
    assign xl_mapped = map_r;
    assign load_miss_exception = lmiss_r;
    assign store_miss_exception = smiss_r;
    assign user_segment_miss_exception = umiss_r;
    assign modification_exception = mod_r;
    assign shutdown_status_bit = shut_r;

    property p_rand_range;
        @(posedge clk) disable iff (rst)
        rand_r >= `RAND_BOT;
    endproperty
    a_rand_range: assert property (p_rand_range)
        else $error("random slot left 63..8");

    property p_rand_wrap;
        @(posedge clk) disable iff (rst)
        rand_r == `RAND_BOT |=> rand_r == `RAND_TOP;
    endproperty
    a_rand_wrap: assert property (p_rand_wrap)
        else $error("random slot did not wrap to 63");

    property p_shut_sticky;
        @(posedge clk) disable iff (rst)
        shut_r |=> shut_r;
    endproperty
    a_shut_sticky: assert property (p_shut_sticky)
        else $error("shutdown bit cleared without reset");

    property p_probe_fail;
        @(posedge clk) disable iff (rst)
        do_probe && !pr_any |=> sel_fail_r;
    endproperty
    a_probe_fail: assert property (p_probe_fail)
        else $error("probe miss did not set failure bit");

    property p_probe_hit;
        @(posedge clk) disable iff (rst)
        do_probe && pr_any |=> !sel_fail_r && sel_idx_r == $past(pr_slot);
    endproperty
    a_probe_hit: assert property (p_probe_hit)
        else $error("probe hit did not load entry number");

    property p_offset;
        @(posedge clk) disable iff (rst)
        xl_req |=> xl_paddr[11:0] == $past(xl_vaddr[11:0]);
    endproperty
    a_offset: assert property (p_offset)
        else $error("page offset altered");

    property p_mod;
        @(posedge clk) disable iff (rst)
        modification_exception |-> xl_mapped && !store_miss_exception;
    endproperty
    a_mod: assert property (p_mod)
        else $error("modification without valid mapped hit");

    property p_no_map_unmapped;
        @(posedge clk) disable iff (rst)
        xl_req && !mapped_ref |=> !xl_mapped && !user_segment_miss_exception;
    endproperty
    a_no_map_unmapped: assert property (p_no_map_unmapped)
        else $error("lookup on unmapped segment");

    property p_shut_blocks;
        @(posedge clk) disable iff (rst)
        shut_r && xl_req |=> !xl_mapped;
    endproperty
    a_shut_blocks: assert property (p_shut_blocks)
        else $error("translation after shutdown");

    property p_hi_rsv;
        @(posedge clk) disable iff (rst)
        reg_rd && reg_addr == `ADDR_HIGH |=> reg_rdata[5:0] == 6'h00;
    endproperty
    a_hi_rsv: assert property (p_hi_rsv)
        else $error("high stage reserved bits not zero");

    property p_lo_rsv;
        @(posedge clk) disable iff (rst)
        reg_rd && reg_addr == `ADDR_LOW |=> reg_rdata[7:0] == 8'h00;
    endproperty
    a_lo_rsv: assert property (p_lo_rsv)
        else $error("low stage reserved bits not zero");

    property p_sel_rsv;
        @(posedge clk) disable iff (rst)
        reg_rd && reg_addr == `ADDR_SELECT |=>
            reg_rdata[30:14] == 17'h00000 && reg_rdata[7:0] == 8'h00;
    endproperty
    a_sel_rsv: assert property (p_sel_rsv)
        else $error("select reserved bits not zero");

    property p_rand_step;
        @(posedge clk) disable iff (rst)
        !rst && rand_r != `RAND_BOT |=> rand_r == $past(rand_r) - 6'h01;
    endproperty
    a_rand_step: assert property (p_rand_step)
        else $error("random slot skipped a count");

    property p_probe_keep;
        @(posedge clk) disable iff (rst)
        do_probe && !pr_any |=> sel_idx_r == $past(sel_idx_r);
    endproperty
    a_probe_keep: assert property (p_probe_keep)
        else $error("probe miss changed entry number");

    property p_write_idx;
        @(posedge clk) disable iff (rst)
        do_wi |=> sel_ent == $past(stage_ent);
    endproperty
    a_write_idx: assert property (p_write_idx)
        else $error("indexed write did not store stages");

    property p_read_stage;
        @(posedge clk) disable iff (rst)
        do_read |=> hi_vpn_r == $past(sel_ent.virtual_page_number)
            && hi_pid_r == $past(sel_ent.process_identifier)
            && lo_pfn_r == $past(sel_ent.physical_frame_number);
    endproperty
    a_read_stage: assert property (p_read_stage)
        else $error("indexed read did not load stages");

    property p_hit_frame;
        @(posedge clk) disable iff (rst)
        good |=> xl_mapped && xl_paddr[31:12] == $past(xl_ent.physical_frame_number);
    endproperty
    a_hit_frame: assert property (p_hit_frame)
        else $error("hit did not substitute frame number");

    property p_umiss_only;
        @(posedge clk) disable iff (rst)
        user_segment_miss_exception |->
            !xl_mapped && !load_miss_exception && !store_miss_exception;
    endproperty
    a_umiss_only: assert property (p_umiss_only)
        else $error("miss reported beside a hit");

    property p_done;
        @(posedge clk) disable iff (rst)
        xl_req |=> xl_done;
    endproperty
    a_done: assert property (p_done)
        else $error("translation result missing");

    property p_unmapped_pass;
        @(posedge clk) disable iff (rst)
        xl_req && !mapped_ref |=> xl_paddr == $past(xl_vaddr);
    endproperty
    a_unmapped_pass: assert property (p_unmapped_pass)
        else $error("unmapped address altered");
endmodule

// File: pkg/xlate_cfg.svh
`ifndef XLATE_CFG_SVH
`define XLATE_CFG_SVH

`define ENTRIES 64
`define IDX_W 6
`define PAGE_LSB 12
`define VPN_W 20
`define PID_W 6
`define RAND_TOP 6'h3F
`define RAND_BOT 6'h08

`define HI_PID_MSB 11
`define HI_PID_LSB 6
`define LO_N_BIT 11
`define LO_D_BIT 10
`define LO_V_BIT 9
`define LO_G_BIT 8
`define SEL_IDX_MSB 13
`define SEL_IDX_LSB 8
`define SEL_PROBE_BIT 31

`define ADDR_HIGH 4'h0
`define ADDR_LOW 4'h1
`define ADDR_SELECT 4'h2
`define ADDR_RANDOM 4'h3
`define ADDR_STATUS 4'h4
`define ADDR_CMD 4'h5

`define CMD_PROBE 32'h00000001
`define CMD_READ 32'h00000002
`define CMD_WRITE_IDX 32'h00000004
`define CMD_WRITE_RAND 32'h00000008

`endif

// File: pkg/xlate_pkg.sv
package xlate_pkg;
    typedef logic [3:0] reg_addr_t;
    typedef logic [31:0] word_t;
    typedef logic [19:0] page_t;
    typedef logic [5:0] slot_t;
    typedef struct packed {
        logic [19:0] virtual_page_number;
        logic [5:0] process_identifier;
        logic [5:0] zero_hi;
        logic [19:0] physical_frame_number;
        logic n;
        logic d;
        logic v;
        logic g;
        logic [7:0] zero_lo;
    } entry_t;
endpackage

// File: dv/core_model.sv
`timescale 1ns/1ps
module core_model (
    input wire logic clk,
    output xlate_pkg::reg_addr_t reg_addr,
    output xlate_pkg::word_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire xlate_pkg::word_t reg_rdata,
    output logic xl_req,
    output xlate_pkg::word_t xl_vaddr,
    output logic xl_store,
    output logic xl_user_mode,
    input wire xlate_pkg::word_t xl_paddr,
    input wire logic [6:0] xl_flags
);
    import xlate_pkg::*;
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        xl_req = 1'b0;
        xl_vaddr = 32'h0;
        xl_store = 1'b0;
        xl_user_mode = 1'b0;
    end
    task automatic wr(input reg_addr_t a, input word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input reg_addr_t a, output word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Result stands one cycle after the request edge
    task automatic xl(input word_t va, input logic st, output word_t pa,
            output logic [6:0] f);
        @(posedge clk);
        xl_req <= 1'b1;
        xl_vaddr <= va;
        xl_store <= st;
        @(posedge clk);
        xl_req <= 1'b0;
        xl_vaddr <= ~va;
        #1 pa = xl_paddr;
        f = xl_flags;
    endtask
endmodule

// File: dv/virtual_page_translation_buffer_test.sv
`timescale 1ns/1ps
`include "xlate_cfg.svh"
module virtual_page_translation_buffer_test;
    import xlate_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    reg_addr_t reg_addr;
    word_t reg_wdata, reg_rdata, xl_vaddr, xl_paddr, d;
    logic reg_wr, reg_rd, xl_req, xl_store, xl_user_mode;
    logic xl_done, xl_uncached, xl_mapped, lm, sm, um, md, sd;
    logic [6:0] flags;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    assign flags = {xl_done, xl_mapped, xl_uncached, lm, sm, um, md};
    page_xlate uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .xl_req(xl_req), .xl_vaddr(xl_vaddr),
        .xl_store(xl_store), .xl_user_mode(xl_user_mode),
        .xl_done(xl_done), .xl_paddr(xl_paddr), .xl_uncached(xl_uncached),
        .xl_mapped(xl_mapped), .load_miss_exception(lm),
        .store_miss_exception(sm), .user_segment_miss_exception(um),
        .modification_exception(md), .shutdown_status_bit(sd));
    core_model core (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .xl_req(xl_req), .xl_vaddr(xl_vaddr), .xl_store(xl_store),
        .xl_user_mode(xl_user_mode), .xl_paddr(xl_paddr), .xl_flags(flags));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input string n, input word_t e, input word_t g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic results();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic put(input int i, input word_t hi, input word_t lo);
        core.wr(`ADDR_HIGH, hi);
        core.wr(`ADDR_LOW, lo);
        core.wr(`ADDR_SELECT, {18'h0, i[5:0], 8'h0});
        core.wr(`ADDR_CMD, `CMD_WRITE_IDX);
    endtask
    task automatic tr(input word_t va, input logic st, input word_t pa,
            input logic [6:0] e);
        word_t p;
        logic [6:0] f;
        core.xl(va, st, p, f);
        chk("flags", {25'h0, e}, {25'h0, f});
        chk("paddr", pa, p);
    endtask
    task automatic rchk(input reg_addr_t a, input word_t e);
        core.rd(a, d);
        chk("reg", e, d);
    endtask
    task automatic t_map();
        put(5, 32'h004000C0, 32'h12345600);
        tr(32'h00400ABC, 0, 32'h12345ABC, 7'h60);
        core.wr(`ADDR_HIGH, 32'h00400100);
        tr(32'h00400ABC, 0, 32'h00400ABC, 7'h42);
        put(6, 32'hC0001000, 32'hABCDEF00);
        core.wr(`ADDR_HIGH, 32'h000001C0);
        tr(32'hC0001123, 0, 32'hABCDE123, 7'h70);
        tr(32'h80001234, 0, 32'h80001234, 7'h40);
    endtask
    task automatic t_attr();
        put(7, 32'h00500000, 32'h00000400);
        tr(32'h00500010, 0, 32'h00000010, 7'h68);
        tr(32'h00500010, 1, 32'h00000010, 7'h64);
        put(8, 32'h00600000, 32'h00000200);
        tr(32'h00600004, 1, 32'h00000004, 7'h61);
        tr(32'h00600004, 0, 32'h00000004, 7'h60);
        core.wr(`ADDR_SELECT, 32'h00000800);
        core.wr(`ADDR_CMD, `CMD_READ);
        rchk(`ADDR_LOW, 32'h00000200);
    endtask
    task automatic t_regs();
        core.wr(`ADDR_HIGH, 32'hFFFFFFFF);
        rchk(`ADDR_HIGH, 32'hFFFFFFC0);
        core.wr(`ADDR_LOW, 32'hFFFFFF00);
        rchk(`ADDR_LOW, 32'hFFFFFF00);
        core.wr(`ADDR_SELECT, 32'h80003F00);
        rchk(`ADDR_SELECT, 32'h80003F00);
        rchk(4'hF, 32'h0);
    endtask
    task automatic t_probe();
        core.wr(`ADDR_HIGH, 32'h004000C0);
        core.wr(`ADDR_CMD, `CMD_PROBE);
        rchk(`ADDR_SELECT, 32'h00000500);
        core.wr(`ADDR_HIGH, 32'h004010C0);
        core.wr(`ADDR_CMD, `CMD_PROBE);
        rchk(`ADDR_SELECT, 32'h80000500);
        core.wr(`ADDR_SELECT, 32'h00000600);
        core.wr(`ADDR_CMD, `CMD_READ);
        rchk(`ADDR_HIGH, 32'hC0001000);
        rchk(`ADDR_LOW, 32'hABCDEF00);
    endtask
    task automatic t_rand();
        core.rd(`ADDR_RANDOM, d);
        chk("rand", 1, 32'(d[31:14] == 0 && d[7:0] == 0 && d[13:8] >= 8));
        core.wr(`ADDR_HIGH, 32'h00700000);
        core.wr(`ADDR_LOW, 32'h77777600);
        core.wr(`ADDR_CMD, `CMD_WRITE_RAND);
        core.wr(`ADDR_CMD, `CMD_PROBE);
        core.rd(`ADDR_SELECT, d);
        chk("slot", 1, 32'(d[31] == 0 && d[13:8] >= 8));
    endtask
    task automatic t_shut();
        rchk(`ADDR_STATUS, 32'h0);
        put(9, 32'h004000C0, 32'h12345600);
        tr(32'h00400ABC, 0, 32'h00400ABC, 7'h40);
        chk("shutdown", 1, {31'h0, sd});
        rchk(`ADDR_STATUS, 32'h1);
        tr(32'h00500010, 1, 32'h00500010, 7'h40);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 64; i++) begin
            put(i, 32'hFFF00000 | (i << 12), 32'h0);
        end
        t_map();
        t_attr();
        t_regs();
        t_probe();
        t_rand();
        t_shut();
        results();
    end
endmodule
